// ### shared/cms_pkg.sv
// package: register map, field layout and carriers for the module support block
package cms_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // minimum reset hold expressed in double-rate clock cycles (kept by system)
  localparam int unsigned RESET_MIN_DRCLK = 41;
  // self-test duration in cycles (plain default, not documented)
  localparam int unsigned SELFTEST_CYCLES = 16;
  localparam int unsigned CHECKSUM_WORDS  = 8;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_MEM_WORD = 8'h10;
  localparam logic [7:0] OFF_ACK_CTRL = 8'h14;

  // control register fields
  localparam int unsigned CTRL_ZERO_IS_MSG  = 0;
  localparam int unsigned CTRL_TWO_IS_EXT   = 1;
  localparam int unsigned CTRL_THREE_IS_ACK = 2;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // status register fields
  localparam int unsigned ST_INIT_SELF  = 0;
  localparam int unsigned ST_PRIMARY    = 1;
  localparam int unsigned ST_PROC_NUM   = 2;
  localparam int unsigned ST_FAULT      = 3;
  localparam int unsigned ST_INIT_DONE  = 4;

  // interrupt status bits
  localparam int unsigned EV_BAD_ACCESS = 0;
  localparam int unsigned EV_MSG        = 1;
  localparam int unsigned EV_IRQ0       = 2;
  localparam int unsigned EV_IRQ1       = 3;
  localparam int unsigned EV_IRQ2       = 4;
  localparam int unsigned EV_EXT        = 5;
  localparam int unsigned EV_IRQ3       = 6;
  localparam int unsigned EV_CKSUM      = 7;
  localparam int unsigned NUM_EV        = 8;
  localparam int unsigned NUM_PINS      = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    CMS_ST_RESET = 4'b0001,
    CMS_ST_TEST  = 4'b0010,
    CMS_ST_SUM   = 4'b0100,
    CMS_ST_RUN   = 4'b1000
  } cms_init_e;

  typedef struct packed {
    logic       init_self;
    logic       primary;
    logic       proc_num;
  } cms_straps_s;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } cms_word_s;
endpackage

// ### core/cms_pin_sync.sv
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/100ps
module cms_pin_sync
  import cms_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_next;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // change only counts once stages two and three agree
      assign level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level[i];
    end
  endgenerate

  // stages run through reset so strap pins are settled at release
  always_ff @(posedge aclk) begin
    s1_reg <= pin;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (!aresetn) begin
      level <= s3_reg;
    end else begin
      level <= level_next;
    end
  end
endmodule

// ### core/cms_self_test.sv
// power-up self-test timer and eight-word zero checksum
`timescale 1ns/100ps
module cms_self_test
  import cms_pkg::*;
#(
  parameter int unsigned TEST_CYCLES = SELFTEST_CYCLES,
  parameter int unsigned WORDS       = CHECKSUM_WORDS
) (
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire cms_word_s mem_word,
  output logic           test_done,
  output logic           sum_done,
  output logic           sum_ok
);
  logic [15:0] tcnt_reg;
  logic [7:0]  wcnt_reg;
  logic [31:0] sum_reg;
  logic [31:0] sum_next;
  logic        last_word;

  assign sum_next  = sum_reg + mem_word.data;
  assign last_word = (wcnt_reg == 8'(WORDS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tcnt_reg  <= '0;
      test_done <= 1'b0;
    end else if (!test_done) begin
      tcnt_reg  <= tcnt_reg + 16'h0001;
      test_done <= (tcnt_reg == 16'(TEST_CYCLES - 1));
    end
  end

  // words are only accepted once the self-test has passed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt_reg <= '0;
      sum_reg  <= '0;
      sum_done <= 1'b0;
      sum_ok   <= 1'b0;
    end else if (test_done && !sum_done && mem_word.valid) begin
      sum_reg  <= sum_next;
      wcnt_reg <= wcnt_reg + 8'h01;
      if (last_word) begin
        sum_done <= 1'b1;
        sum_ok   <= (sum_next == 32'h0000_0000);
      end
    end
  end
endmodule

// ### core/cms_module_support.sv
// module support: strap capture, init fault sequence, interrupt pins, AXI4-Lite regs
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - sample bad access cycle after last ready
// - bad access strap selects initializing processor
// - reset clears logic, then re-initializes
// - reset ignores inputs, outputs deasserted or floated
// - fault asserted during self-test, cleared on pass
// - eight-word zero checksum, mismatch latches fault
// - line zero is message request or interrupt
// - line zero strap selects bus role, number
// - line one is direct interrupt like zero
// - line two direct or external controller request
// - line three direct or open-drain acknowledge
// - acknowledge latched, stable through data states
module cms_module_support
  import cms_pkg::*;
#(
  parameter int unsigned TEST_CYCLES = SELFTEST_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        bad_access_in,
  input  wire logic        last_ready_seen,
  input  wire logic        irq_line_zero,
  input  wire logic        irq_line_one,
  input  wire logic        irq_line_two,
  input  wire logic        irq_line_three_i,
  output logic             irq_acknowledge_out_o,
  output logic             irq_acknowledge_out_oe_n,
  input  wire logic        data_state_cycle,
  output logic             init_fault_out_o,
  output logic             init_fault_out_oe_n,
  output logic             bus_error_event,
  output logic             primary_master,
  output logic             irq_out
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NUM_PINS:0] pin_raw;
  logic [NUM_PINS:0] pin_lvl;
  logic              bad_lvl;
  logic [3:0]        irq_lvl;
  logic [3:0]        irq_prev_reg;
  logic [3:0]        irq_rise;

  assign pin_raw = {bad_access_in, irq_line_three_i, irq_line_two, irq_line_one,
                    irq_line_zero};
  assign bad_lvl = pin_lvl[NUM_PINS];
  assign irq_lvl = pin_lvl[NUM_PINS-1:0];

  cms_pin_sync #(.WIDTH(NUM_PINS + 1)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (pin_raw),
    .level   (pin_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // reset tracking and strap capture
  logic        was_reset_reg;
  cms_straps_s straps_reg;
  cms_straps_s straps_next;

  // strap levels read while reset is low, caught on the first edge after release
  assign straps_next.init_self = bad_lvl;
  assign straps_next.primary   = irq_lvl[0];
  assign straps_next.proc_num  = ~irq_lvl[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_reset_reg <= 1'b1;
    end else begin
      was_reset_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_reg <= '0;
    end else if (was_reset_reg) begin
      straps_reg <= straps_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // init sequence
  cms_init_e state_reg;
  cms_init_e state_next;
  cms_word_s mem_word;
  logic      test_done;
  logic      sum_done;
  logic      sum_ok;
  logic      fault_reg;
  logic      fault_next;

  cms_self_test #(.TEST_CYCLES(TEST_CYCLES)) u_test (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .mem_word  (mem_word),
    .test_done (test_done),
    .sum_done  (sum_done),
    .sum_ok    (sum_ok)
  );

  always_comb begin
    state_next = state_reg;
    fault_next = fault_reg;
    unique case (state_reg)
      CMS_ST_RESET: begin
        state_next = CMS_ST_TEST;
        fault_next = 1'b1;
      end
      CMS_ST_TEST: begin
        if (test_done) begin
          state_next = CMS_ST_SUM;
          fault_next = 1'b0;
        end
      end
      CMS_ST_SUM: begin
        if (sum_done) begin
          state_next = CMS_ST_RUN;
          fault_next = !sum_ok;
        end
      end
      CMS_ST_RUN: begin
        fault_next = fault_reg;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= CMS_ST_RESET;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fault_reg <= fault_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control, interrupt lines, acknowledge, bad access
  logic [31:0]       ctrl_reg;
  logic [NUM_EV-1:0] irq_stat_reg;
  logic [NUM_EV-1:0] irq_mask_reg;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] stat_clr;
  logic              ack_req_reg;
  logic              running;
  logic              bad_sample;
  logic              zero_is_msg;
  logic              two_is_ext;
  logic              three_is_ack;

  assign running      = state_reg == CMS_ST_RUN;
  assign zero_is_msg  = ctrl_reg[CTRL_ZERO_IS_MSG];
  assign two_is_ext   = ctrl_reg[CTRL_TWO_IS_EXT];
  assign three_is_ack = ctrl_reg[CTRL_THREE_IS_ACK];
  // low-then-high qualified by the synchroniser, so rises are clean edges
  assign irq_rise     = irq_lvl & ~irq_prev_reg;
  // only meaningful on the cycle after the final ready of a transaction
  assign bad_sample   = running && last_ready_seen && bad_lvl;

  always_comb begin
    ev_set                = '0;
    ev_set[EV_BAD_ACCESS] = bad_sample;
    ev_set[EV_MSG]        = irq_rise[0] && zero_is_msg;
    ev_set[EV_IRQ0]       = irq_rise[0] && !zero_is_msg;
    ev_set[EV_IRQ1]       = irq_rise[1];
    ev_set[EV_IRQ2]       = irq_rise[2] && !two_is_ext;
    ev_set[EV_EXT]        = irq_rise[2] && two_is_ext;
    ev_set[EV_IRQ3]       = irq_rise[3] && !three_is_ack;
    ev_set[EV_CKSUM]      = (state_reg == CMS_ST_SUM) && sum_done && !sum_ok;
    if (!running && !ev_set[EV_CKSUM]) begin
      ev_set = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev_reg <= '0;
    end else begin
      irq_prev_reg <= irq_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] wr_bits;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wr_bits[gb*8 +: 8] = w_strb_reg[gb] ? w_data_reg[gb*8 +: 8] : 8'h00;
    end
  endgenerate

  assign wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign wr_hit   = aw_addr_reg == OFF_CTRL || aw_addr_reg == OFF_IRQ_STAT ||
                    aw_addr_reg == OFF_IRQ_MASK || aw_addr_reg == OFF_MEM_WORD ||
                    aw_addr_reg == OFF_ACK_CTRL;
  assign rd_hit   = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STATUS ||
                    s_axi_araddr == OFF_IRQ_STAT || s_axi_araddr == OFF_IRQ_MASK;
  assign stat_clr = (wr_fire && aw_addr_reg == OFF_IRQ_STAT) ?
                    wr_bits[NUM_EV-1:0] : '0;
  assign mem_word.data  = w_data_reg;
  assign mem_word.valid = wr_fire && aw_addr_reg == OFF_MEM_WORD;

  always_comb begin
    status_word                = '0;
    status_word[ST_INIT_SELF]  = straps_reg.init_self;
    status_word[ST_PRIMARY]    = straps_reg.primary;
    status_word[ST_PROC_NUM]   = straps_reg.proc_num;
    status_word[ST_FAULT]      = fault_reg;
    status_word[ST_INIT_DONE]  = running;
  end

  assign rd_word = (s_axi_araddr == OFF_CTRL)     ? ctrl_reg :
                   (s_axi_araddr == OFF_STATUS)   ? status_word :
                   (s_axi_araddr == OFF_IRQ_STAT) ? 32'(irq_stat_reg) :
                   (s_axi_araddr == OFF_IRQ_MASK) ? 32'(irq_mask_reg) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg   <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // register writes; hardware set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= CTRL_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      ack_req_reg  <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~stat_clr) | ev_set;
      if (wr_fire && aw_addr_reg == OFF_CTRL) begin
        ctrl_reg <= wr_bits;
      end
      if (wr_fire && aw_addr_reg == OFF_IRQ_MASK) begin
        irq_mask_reg <= wr_bits[NUM_EV-1:0];
      end
      if (wr_fire && aw_addr_reg == OFF_ACK_CTRL) begin
        ack_req_reg <= wr_bits[0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_fault_out_o         <= 1'b0;
      init_fault_out_oe_n      <= 1'b1;
      irq_acknowledge_out_o    <= 1'b0;
      irq_acknowledge_out_oe_n <= 1'b1;
      bus_error_event          <= 1'b0;
      primary_master           <= 1'b0;
      irq_out                  <= 1'b0;
    end else begin
      // open drain: pull low when asserted, else release
      init_fault_out_o         <= 1'b0;
      init_fault_out_oe_n      <= !fault_next;
      irq_acknowledge_out_o    <= 1'b0;
      // the pin flop is the latch itself, so it never lags into a data state
      if (!data_state_cycle) begin
        irq_acknowledge_out_oe_n <= !(three_is_ack && ack_req_reg);
      end
      bus_error_event          <= bad_sample;
      primary_master           <= was_reset_reg ? straps_next.primary : straps_reg.primary;
      irq_out                  <= |(((irq_stat_reg & ~stat_clr) | ev_set) & irq_mask_reg);
    end
  end
endmodule

// ### verif/cms_module_support_assertions.sv
// concurrent checks on the module support block ports
`timescale 1ns/100ps
module cms_module_support_checker #(
  parameter int unsigned TEST_CYCLES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic last_ready_seen,
  input wire logic bus_error_event,
  input wire logic data_state_cycle,
  input wire logic irq_acknowledge_out_oe_n,
  input wire logic init_fault_out_oe_n,
  input wire logic primary_master,
  input wire logic irq_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_reset_quiet;
    $rose(aresetn) |-> init_fault_out_oe_n && irq_acknowledge_out_oe_n && !irq_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active at release");
  property p_fault_test;
    $rose(aresetn) |=> !init_fault_out_oe_n [*2];
  endproperty
  a_fault_test: assert property (p_fault_test) else $error("fault not shown in self-test");
  localparam int FAULT_END = int'(TEST_CYCLES) + 1;
  property p_fault_release;
    $rose(aresetn) |-> ##[FAULT_END:FAULT_END] init_fault_out_oe_n;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault never released");
  property p_err_pulse;
    bus_error_event |=> !bus_error_event;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error event longer than one cycle");
  property p_err_cause;
    bus_error_event |-> $past(last_ready_seen);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error event off the sample cycle");
  property p_ack_hold;
    $past(data_state_cycle) && $past(aresetn) |-> $stable(irq_acknowledge_out_oe_n);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge moved in data state");
  property p_strap_hold;
    $past(aresetn) && $past(aresetn, 2) |-> $stable(primary_master);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("role changed after release");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule

bind cms_module_support cms_module_support_checker #(.TEST_CYCLES(TEST_CYCLES))
  i_cms_module_support_checker (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .last_ready_seen, .bus_error_event, .data_state_cycle,
  .irq_acknowledge_out_oe_n, .init_fault_out_oe_n, .primary_master, .irq_out);

// ### verif/cms_far_end.sv
// far-side model: reset source, bus error logic and interrupt sources
`timescale 1ns/100ps
module cms_far_end (
  input  wire logic aclk,
  input  wire logic irq_acknowledge_out_oe_n,
  output logic      aresetn,
  output logic      bad_access_in,
  output logic      last_ready_seen,
  output logic      irq_line_zero,
  output logic      irq_line_one,
  output logic      irq_line_two,
  output logic      irq_line_three_i
);
  logic line_three_drive;
  initial begin
    aresetn = 1'b0;
    bad_access_in = 1'b0;
    last_ready_seen = 1'b0;
    irq_line_zero = 1'b0;
    irq_line_one = 1'b0;
    irq_line_two = 1'b0;
    line_three_drive = 1'b0;
  end
  // an asserted acknowledge wins over whatever the source drives
  assign irq_line_three_i = irq_acknowledge_out_oe_n ? line_three_drive : 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // 21 bus cycles cover 42 double-rate cycles; 5 only for the first power-up
  task automatic do_reset(input int cycles, input logic self_init, input logic prim);
    bad_access_in <= self_init;
    irq_line_zero <= prim;
    aresetn <= 1'b0;
    repeat (cycles) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic idle();
    bad_access_in <= 1'b0;
    irq_line_zero <= 1'b0;
  endtask
  task automatic drive_line(input int line, input logic v);
    case (line)
      0: irq_line_zero <= v;
      1: irq_line_one <= v;
      2: irq_line_two <= v;
      default: line_three_drive <= v;
    endcase
  endtask
  // lines rest low, so each pulse starts after at least three low cycles
  task automatic pulse(input int line);
    @(posedge aclk);
    drive_line(line, 1'b1);
    repeat (8) @(posedge aclk);
    drive_line(line, 1'b0);
    repeat (3) @(posedge aclk);
  endtask
  task automatic bad_cycle(input logic v);
    @(posedge aclk);
    bad_access_in <= v;
    repeat (5) @(posedge aclk);
    last_ready_seen <= 1'b1;
    @(posedge aclk);
    last_ready_seen <= 1'b0;
    bad_access_in <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// ### verif/cms_module_support_test.sv
// self-checking bench for the module support block
`timescale 1ns/100ps
module cms_module_support_test;
  import cms_pkg::*;
  logic        aclk = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, data_state_cycle = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        aresetn, bad_access_in, last_ready_seen, bus_error_event, primary_master;
  logic        irq_line_zero, irq_line_one, irq_line_two, irq_line_three_i, irq_out;
  logic        irq_acknowledge_out_oe_n, init_fault_out_oe_n;
  logic        irq_acknowledge_out_o, init_fault_out_o;
  int          num_errors = 0, checked = 0, seed = 82724, err_seen = 0;
  logic [65:0] exp_q[$];
  logic [2:0]  mode_t[6] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h2, 3'h0};
  int          line_t[6] = '{0, 0, 1, 2, 2, 3};
  int          bit_t[6] = '{EV_IRQ0, EV_MSG, EV_IRQ1, EV_IRQ2, EV_EXT, EV_IRQ3};

  cms_module_support #(.TEST_CYCLES(2)) i_cms_module_support (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bad_access_in, .last_ready_seen,
    .irq_line_zero, .irq_line_one, .irq_line_two, .irq_line_three_i,
    .irq_acknowledge_out_o, .irq_acknowledge_out_oe_n, .data_state_cycle,
    .init_fault_out_o, .init_fault_out_oe_n, .bus_error_event, .primary_master, .irq_out);
  cms_far_end i_cms_far_end (.aclk, .irq_acknowledge_out_oe_n, .aresetn, .bad_access_in,
    .last_ready_seen, .irq_line_zero, .irq_line_one, .irq_line_two, .irq_line_three_i);

  initial begin
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    num_errors++;
    $display("FAIL %0t wait ran out", $time);
    wrap_up();
  endtask
  // answers are strictly in request order, one transfer at a time
  always @(posedge aclk) begin : watch
    logic [65:0] note;
    if (bus_error_event === 1'b1) err_seen++;
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      note = (exp_q.size() != 0) ? exp_q.pop_front() : {32'h0, 34'h1};
      check(s_axi_rvalid ? {s_axi_rdata & note[65:34], s_axi_rresp}
                         : {32'h0, s_axi_bresp}, note[33:0]);
    end
  end
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    exp_q.push_back({64'h0, r});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) give_up();
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] m, d, input logic [1:0] r);
    int n = 0;
    exp_q.push_back({m, d & m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) give_up();
  endtask
  // sel 0 fault pin, 1 acknowledge pin, 2 interrupt output
  task automatic await(input int sel, input logic v);
    logic s;
    for (int n = 0; n < 60; n++) begin
      @(posedge aclk);
      s = sel == 0 ? init_fault_out_oe_n : sel == 1 ? irq_acknowledge_out_oe_n : irq_out;
      if (s === v) return;
    end
    give_up();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] sv, sum, w;
    logic        self, prim;
    sv = $random(seed);
    for (int run = 0; run < 2; run++) begin
      self = sv[0] ^ run[0];
      prim = sv[1] ^ run[0];
      @(posedge aclk);
      i_cms_far_end.do_reset(run == 0 ? 5 : 21, self, prim);
      check({init_fault_out_oe_n, irq_acknowledge_out_oe_n, irq_out}, 3'h6);
      await(0, 1'b0);
      await(0, 1'b1);
      i_cms_far_end.idle();
      check(primary_master, prim);
      axi_read(OFF_STATUS, 32'h0000_0007, {29'h0, ~prim, prim, self}, RESP_OKAY);
      axi_read(OFF_IRQ_STAT, 32'hffff_ffff, 32'h0, RESP_OKAY);
      sum = 32'h0;
      for (int i = 0; i < CHECKSUM_WORDS - 1; i++) begin
        w = $random(seed);
        sum += w;
        axi_write(OFF_MEM_WORD, w, RESP_OKAY);
      end
      axi_write(OFF_MEM_WORD, 32'h0 - sum + run, RESP_OKAY);
      if (run == 1) begin
        await(0, 1'b0);
        repeat (20) @(posedge aclk);
        check(init_fault_out_oe_n, 1'b0);
        axi_read(OFF_IRQ_STAT, 32'h0000_0080, 32'h0000_0080, RESP_OKAY);
      end else begin
        axi_read(OFF_STATUS, 32'h0000_0018, 32'h0000_0010, RESP_OKAY);
        axi_write(OFF_IRQ_MASK, 32'h0000_00ff, RESP_OKAY);
        for (int k = 0; k < 6; k++) begin
          axi_write(OFF_CTRL, {29'h0, mode_t[k]}, RESP_OKAY);
          i_cms_far_end.pulse(line_t[k]);
          await(2, 1'b1);
          axi_read(OFF_IRQ_STAT, 32'h0000_007e, 32'h1 << bit_t[k], RESP_OKAY);
          axi_write(OFF_IRQ_STAT, 32'h0000_00ff, RESP_OKAY);
          await(2, 1'b0);
        end
        axi_write(OFF_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
        i_cms_far_end.pulse(1);
        check(irq_out, 1'b0);
        axi_read(OFF_IRQ_STAT, 32'h0000_0008, 32'h0000_0008, RESP_OKAY);
        axi_write(OFF_IRQ_MASK, 32'h0000_0008, RESP_OKAY);
        await(2, 1'b1);
        i_cms_far_end.bad_cycle(1'b0);
        check(err_seen, 34'h0);
        i_cms_far_end.bad_cycle(1'b1);
        check(err_seen, 34'h1);
        axi_read(OFF_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
        axi_write(OFF_CTRL, 32'h0000_0004, RESP_OKAY);
        data_state_cycle <= 1'b1;
        axi_write(OFF_ACK_CTRL, 32'h0000_0001, RESP_OKAY);
        repeat (6) @(posedge aclk);
        check(irq_acknowledge_out_oe_n, 1'b1);
        data_state_cycle <= 1'b0;
        await(1, 1'b0);
        check({irq_acknowledge_out_o, init_fault_out_o}, 2'h0);
        data_state_cycle <= 1'b1;
        axi_write(OFF_ACK_CTRL, 32'h0000_0000, RESP_OKAY);
        repeat (6) @(posedge aclk);
        check(irq_acknowledge_out_oe_n, 1'b0);
        data_state_cycle <= 1'b0;
        await(1, 1'b1);
        axi_read(8'hf0, 32'hffff_ffff, 32'h0, RESP_SLVERR);
        axi_write(8'hf0, 32'h1234_5678, RESP_SLVERR);
      end
      $display("run %0d done", run);
    end
    wrap_up();
  end
endmodule
